// >>> bench/rcs_board.sv
// Board model: reset source and the pulled-up shared reset pin.
`timescale 1ns/1ps
`default_nettype none
module rcs_board (
	// Requests from the bench.
	input wire logic hold_rst,
	input wire logic pull_low,
	// Device side of the shared pin.
	input wire logic pin_o,
	input wire logic pin_oe_n,
	// Board outputs.
	output wire logic reset,
	output wire logic pin
);
	// Reset counts as asserted from power-up until released.
	assign reset = (hold_rst !== 1'b0);
	// Released pin floats to the pull-up unless the board pulls it low.
	assign pin = (pin_oe_n === 1'b1) ? !pull_low : pin_o;
endmodule
`default_nettype wire

// >>> bench/rcs_top_properties.sv
// Port checker of the start-up sequencer.
`timescale 1ns/1ps
`default_nettype none
module rcs_props (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Observed ports.
	input wire logic core_run,
	input wire logic [31:0] core_start_addr,
	input wire logic [5:0] clk_ratio,
	input wire logic [2:0] boot_mode,
	input wire logic shared_rst_o,
	input wire logic shared_rst_oe_n,
	input wire logic pll_update,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o
);
	logic [12:0] wait_r;
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	// Counts edges spent waiting for the core to run.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) wait_r <= 13'h0000;
		else if (core_run) wait_r <= 13'h0000;
		else wait_r <= wait_r + 13'h0001;
	end
	rst_state_a: assert property ($fell(reset) |-> !core_run && !shared_rst_oe_n)
		else $error("state after reset is wrong");
	lock_wait_a: assert property ($rose(core_run) |-> wait_r >= 13'h1000 && wait_r <= 13'h1008)
		else $error("lock wait length is wrong");
	start_addr_a: assert property ($rose(core_run) |=> core_start_addr == 32'h00090000)
		else $error("start address is wrong");
	ratio_code_a: assert property (clk_ratio inside {6'h08, 6'h10, 6'h20})
		else $error("clock ratio is not legal");
	straps_held_a: assert property (core_run |=> $stable(clk_ratio) && $stable(boot_mode))
		else $error("strap values changed while running");
	ind_out_a: assert property ($rose(core_run) && !shared_rst_oe_n |-> ##[0:1] shared_rst_o)
		else $error("indicator not raised");
	pin_input_a: assert property ($rose(shared_rst_oe_n) |-> wb_ack_o || $past(wb_ack_o))
		else $error("pin turned to input without a write");
	pll_gate_a: assert property (pll_update |-> core_run ##1 !pll_update)
		else $error("pll update outside run");
	ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack timing is wrong");
	// Main scenarios reached.
	cover property ($rose(core_run));
	cover property ($rose(shared_rst_oe_n));
	cover property (pll_update);
endmodule
bind rcs_top rcs_props chk_u (.clk(clk), .reset(reset), .core_run(core_run),
	.core_start_addr(core_start_addr), .clk_ratio(clk_ratio), .boot_mode(boot_mode),
	.shared_rst_o(shared_rst_o), .shared_rst_oe_n(shared_rst_oe_n), .pll_update(pll_update),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench of the start-up sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("CHECK FAILED %s exp %h got %h", n, e, g); \
	end \
end
module tb_top;
	logic clk = 1'b0, hold_rst = 1'b1, pull_low = 1'b0, wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic [1:0] ratio_sel_pins = 2'h0;
	logic [2:0] boot_sel_pins = 3'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, rd;
	wire logic reset, shared_rst_i, shared_rst_o, shared_rst_oe_n, core_run, core_reset;
	wire logic pll_update, wb_ack_o;
	wire logic [31:0] core_start_addr, wb_dat_o;
	wire logic [5:0] clk_ratio;
	wire logic [2:0] boot_mode;
	wire logic [7:0] pll_mult, pll_div;
	int error_cnt = 0, cmp_count = 0;
	logic [10:0] rows [4] = '{{5'h05, 6'h08}, {5'h0A, 6'h20}, {5'h17, 6'h10}, {5'h18, 6'h08}};
	rcs_top dut_u (.clk(clk), .reset(reset), .ratio_sel_pins(ratio_sel_pins),
		.boot_sel_pins(boot_sel_pins), .shared_rst_i(shared_rst_i), .shared_rst_o(shared_rst_o),
		.shared_rst_oe_n(shared_rst_oe_n), .core_run(core_run), .core_reset(core_reset),
		.core_start_addr(core_start_addr), .clk_ratio(clk_ratio), .boot_mode(boot_mode),
		.pll_mult(pll_mult), .pll_div(pll_div), .pll_update(pll_update), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	rcs_board board_u (.hold_rst(hold_rst), .pull_low(pull_low), .pin_o(shared_rst_o),
		.pin_oe_n(shared_rst_oe_n), .reset(reset), .pin(shared_rst_i));
	// Free-running reference clock.
	always #5 clk = ~clk;
	// One classic bus cycle, held until ack.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask
	// Waits a bounded time for the core to run.
	task automatic wait_run();
		int n = 0;
		while (core_run !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000) error_cnt++;
		@(posedge clk);
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("errors %0d checks %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog.
	initial begin
		#400us;
		error_cnt++;
		print_verdict();
	end
	// Strap rows first, then the running checks.
	initial begin
		for (int i = 0; i < 4; i++) begin
			{ratio_sel_pins, boot_sel_pins} <= rows[i][10:6];
			@(posedge clk);
			hold_rst <= 1'b1;
			repeat (4) @(posedge clk);
			hold_rst <= 1'b0;
			repeat (2) @(posedge clk);
			`CHK("held", 1'b1, core_reset)
			`CHK("ind_low", 1'b0, shared_rst_o)
			wb(1'b1, 8'h04, 32'h0000_0203);
			`CHK("early_pll", 8'h00, pll_mult)
			wait_run();
			`CHK("ratio", rows[i][5:0], clk_ratio)
			`CHK("boot", rows[i][8:6], boot_mode)
			`CHK("start", 32'h00090000, core_start_addr)
			`CHK("oe_n", 1'b0, shared_rst_oe_n)
			`CHK("ind", 1'b1, shared_rst_o)
		end
		{ratio_sel_pins, boot_sel_pins} <= 5'h0F;
		repeat (6) @(posedge clk);
		`CHK("latched", 9'h008, {boot_mode, clk_ratio})
		wb(1'b1, 8'h04, 32'h0000_0305);
		`CHK("pll", 16'h0305, {pll_div, pll_mult})
		wb(1'b0, 8'h04, 32'h0);
		`CHK("pm_read", 32'h00000305, rd)
		wb(1'b0, 8'h00, 32'h0);
		`CHK("status", 32'h000003EC, rd)
		wb(1'b0, 8'h0C, 32'h0);
		`CHK("vector", 32'h00090000, rd)
		wb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		pull_low <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK("pin_out_kept", 1'b1, core_run)
		pull_low <= 1'b0;
		wb(1'b1, 8'h08, 32'h1);
		`CHK("pin_in", 1'b1, shared_rst_oe_n)
		pull_low <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK("run_rst", 1'b0, core_run)
		pull_low <= 1'b0;
		wait_run();
		`CHK("rerun", 1'b1, core_run)
		print_verdict();
	end
endmodule
`default_nettype wire

// >>> core/rcs_defines.vh
// Constants for the start-up reset and clock configuration block.
`ifndef RCS_DEFINES_VH
`define RCS_DEFINES_VH
// Wishbone register offsets (byte addresses).
`define RCS_OFF_STATUS 8'h00
`define RCS_OFF_PWR_MGMT 8'h04
`define RCS_OFF_RUN_RST 8'h08
`define RCS_OFF_RESET_VEC 8'h0C
// Field positions.
`define RCS_RUN_RST_EN_BIT 0
`define RCS_PM_MULT_LSB 0
`define RCS_PM_DIV_LSB 8
// Ratio select codes.
`define RCS_RATIO_8 2'h0
`define RCS_RATIO_32 2'h1
`define RCS_RATIO_16 2'h2
`define RCS_RATIO_RSVD 2'h3
// Reset values.
`define RCS_PM_RESET 16'h0000
`define RCS_RUN_RST_RESET 1'h0
`define RCS_RESET_VECTOR 32'h0009_0000
// Lock wait in reference clock cycles.
`define RCS_LOCK_CYCLES 13'h1000
`endif

// >>> core/rcs_sync.v
// Two-flop synchroniser bank for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module rcs_sync #(
	parameter W = 1
) (
	// Clock and reset.
	input wire clk,
	input wire reset,
	// Data.
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;
	// First stage is read only by the second stage.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end else begin
			meta_r <= d;
			sync_r <= meta_r;
		end
	end
	assign q = sync_r;
endmodule
`default_nettype wire

// >>> core/rcs_top.v
// Start-up reset, clock ratio and boot configuration sequencer.
// Operation
// - Ratio pins give 8:1 for 00, 32:1 for 01, 16:1 for 10; 11 reserved.
// - Software may rewrite PLL multiplier and divider any time after core leaves reset.
// - After reset release wait 4096 reference cycles for PLL lock.
// - After the wait the core starts at the fixed reset vector.
// - While reset is asserted all logic sits in a known state.
// - After reset the shared pin works as reset indicator output.
// - Shared pin becomes running reset input only when control bit 0 set.
// - Boot mode comes from the three boot select pins.
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rcs_defines.vh"
module rcs_top (
	// Clock and reset (reset is the active-high, board-driven reset pin).
	input wire clk,
	input wire reset,
	// Strap pins.
	input wire [1:0] ratio_sel_pins,
	input wire [2:0] boot_sel_pins,
	// Shared reset indicator / running reset pin.
	input wire shared_rst_i,
	output reg shared_rst_o,
	output reg shared_rst_oe_n,
	// Core start-up outputs.
	output reg core_run,
	output reg core_reset,
	output reg [31:0] core_start_addr,
	output reg [5:0] clk_ratio,
	output reg [2:0] boot_mode,
	output reg [7:0] pll_mult,
	output reg [7:0] pll_div,
	output reg pll_update,
	// Wishbone slave.
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o
);
	// Sequencer states: strap latch, PLL lock wait, core running.
	// The latch state lasts three edges so that the strap levels have
	// crossed both synchroniser stages before the last sample is kept.
	localparam ST_LATCH = 2'h0;
	localparam ST_LOCK = 2'h1;
	localparam ST_RUN = 2'h2;
	// Last count of the lock wait, sized to the counter.
	localparam [12:0] LOCK_LAST = `RCS_LOCK_CYCLES - 13'h0001;

	// Ratio code decode; reserved code falls back to the slowest ratio.
	// Only the synchronised code ratio_s is decoded, never the raw pins.
	function [5:0] ratio_of;
		input [1:0] code;
		begin
			case (code)
				`RCS_RATIO_8: ratio_of = 6'h08;
				`RCS_RATIO_32: ratio_of = 6'h20;
				`RCS_RATIO_16: ratio_of = 6'h10;
				default: ratio_of = 6'h08;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	wire [1:0] ratio_s;
	wire [2:0] boot_s;
	wire run_rst_s;
	// Pins cross into the clock domain through two flops.
	// The stages come out of reset at zero, so their output is the real
	// pin level only from the second edge after release onwards.
	rcs_sync #(.W(6)) u_sync (
		.clk(clk),
		.reset(reset),
		.d({ratio_sel_pins, boot_sel_pins, shared_rst_i}),
		.q({ratio_s, boot_s, run_rst_s})
	);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer, lock counter and stored register state.
	reg [1:0] state_r;
	reg [12:0] cnt_r;
	reg [1:0] ratio_code_r;
	reg run_rst_en_r;
	reg [15:0] pm_r;
	reg strap_done_r;
	reg strap_wait_r;
	// Decoded conditions shared by several processes.
	wire running = (state_r == ST_RUN);
	wire run_rst_hit = run_rst_en_r & ~run_rst_s;
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wb_wr = wb_req & wb_we_i;

	// Sequencer: latch straps, wait for lock, then run.
	// Edges one to three after release sample the straps and the last sample
	// wins. The lock count then runs over 4096 edges before the core is let go.
	// A running reset only repeats the lock wait; the straps stay as latched.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_LATCH;
			cnt_r <= 13'h0000;
			ratio_code_r <= 2'h0;
			boot_mode <= 3'h0;
			clk_ratio <= 6'h08;
			strap_done_r <= 1'b0;
			strap_wait_r <= 1'b0;
			core_run <= 1'b0;
			core_reset <= 1'b1;
			core_start_addr <= 32'h0000_0000;
		end else begin
			case (state_r)
				ST_LATCH: begin
					// Straps sampled on each of the three latch edges after release, held until next reset.
					ratio_code_r <= ratio_s;
					clk_ratio <= ratio_of(ratio_s);
					boot_mode <= boot_s;
					strap_wait_r <= 1'b1;
					strap_done_r <= strap_wait_r;
					cnt_r <= 13'h0000;
					if (strap_done_r) begin
						state_r <= ST_LOCK;
					end
				end
				ST_LOCK: begin
					// Count the reference cycles of the PLL lock wait.
					if (cnt_r == LOCK_LAST) begin
						// Release the core at the fixed reset vector.
						state_r <= ST_RUN;
						core_run <= 1'b1;
						core_reset <= 1'b0;
						core_start_addr <= `RCS_RESET_VECTOR;
					end else begin
						cnt_r <= cnt_r + 13'h0001;
					end
				end
				ST_RUN: begin
					// A running reset sends the core back through the lock wait.
					if (run_rst_hit) begin
						state_r <= ST_LOCK;
						cnt_r <= 13'h0000;
						core_run <= 1'b0;
						core_reset <= 1'b1;
					end
				end
				default: begin
					state_r <= ST_LATCH;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared pin: indicator output unless running reset input is enabled.
	// The indicator is low while the core is held and high once it runs.
	// Turning the pin around only after the enable bit is stored keeps
	// the pin driven high in the cycle of the write.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			shared_rst_o <= 1'b0;
			shared_rst_oe_n <= 1'b0;
		end else begin
			shared_rst_o <= running;
			shared_rst_oe_n <= run_rst_en_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register writes; PLL setting accepted only while the core runs.
	// A PLL write before the core runs is still answered but changes nothing,
	// so start-up code cannot disturb the lock wait.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			pm_r <= `RCS_PM_RESET;
			run_rst_en_r <= `RCS_RUN_RST_RESET;
			pll_mult <= 8'h00;
			pll_div <= 8'h00;
			pll_update <= 1'b0;
		end else begin
			pll_update <= 1'b0;
			if (wb_wr && wb_adr_i == `RCS_OFF_PWR_MGMT && running) begin
				if (wb_sel_i[0]) begin
					pm_r[7:0] <= wb_dat_i[7:0];
					pll_mult <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					pm_r[15:8] <= wb_dat_i[15:8];
					pll_div <= wb_dat_i[15:8];
				end
				pll_update <= |wb_sel_i[1:0];
			end
			// The enable bit turns the shared pin into the running reset input.
			if (wb_wr && wb_adr_i == `RCS_OFF_RUN_RST && wb_sel_i[0]) begin
				run_rst_en_r <= wb_dat_i[`RCS_RUN_RST_EN_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus answer: one cycle after the request, unmapped reads return zero.
	// The request is masked while ack stands, so one cycle gives one answer.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`RCS_OFF_STATUS: wb_dat_o <= {19'h00000, boot_mode, ratio_code_r,
						run_rst_s, running, state_r, core_run, strap_done_r,
						2'h0};
					`RCS_OFF_PWR_MGMT: wb_dat_o <= {16'h0000, pm_r};
					`RCS_OFF_RUN_RST: wb_dat_o <= {31'h00000000, run_rst_en_r};
					`RCS_OFF_RESET_VEC: wb_dat_o <= `RCS_RESET_VECTOR;
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire
